// >>> logic/afe_clamp_pkg.sv
// Purpose: Shared constants and types for the channel clamp controller
// Assumes: AXI4-Lite register access, 32-bit data
// Notes: Byte offsets are word aligned
package afe_clamp_pkg;
   localparam int num_ch = 4;
   localparam int addr_w = 8;
   localparam int pix_w = 20;
   localparam logic [addr_w-1:0] off_chan_cfg = 8'h00;
   localparam logic [addr_w-1:0] off_ch_mode = 8'h04;
   localparam logic [addr_w-1:0] off_win_start = 8'h08;
   localparam logic [addr_w-1:0] off_win_end = 8'h0C;
   localparam logic [addr_w-1:0] off_status = 8'h10;
   // Per-channel field layout inside ch_mode, 8 bits per channel
   localparam int ch_field_w = 8;
   localparam int fld_scheme = 0;
   localparam int fld_polarity = 1;
   localparam int fld_clamp_lo = 2;
   localparam int fld_level_lo = 4;
   localparam int fld_dac_lo = 0;
   localparam int fld_count_lo = 2;
   localparam logic [1:0] count_four = 2'h0;
   localparam logic [1:0] count_three = 2'h1;
   localparam logic [1:0] count_two = 2'h2;
   localparam logic [1:0] dac_reset = 2'h0;
   localparam logic [pix_w-1:0] win_reset = 20'h00000;
   localparam logic [1:0] resp_okay = 2'h0;
   localparam logic [1:0] resp_slverr = 2'h2;
   typedef enum logic [1:0] {clamp_pixel, clamp_line, clamp_open_int, clamp_open_ext} clamp_mode_t;
   typedef enum logic [1:0] {level_fixed, level_int_dac, level_ext_pin, level_bad} clamp_level_t;
endpackage

// >>> logic/afe_cfg_if.sv
// Purpose: Configuration carrier between register file and strobe gating
// Assumes: Single clock
// Notes: None
`timescale 1ns/1ps
interface afe_cfg_if;
   logic [3:0] ch_active;
   logic [3:0] scheme_sh;
   logic [3:0] pixel_clamp_en;
   logic [3:0] line_clamp_en;
   logic win_open;
   modport regs (output ch_active, output scheme_sh, output pixel_clamp_en, output line_clamp_en, output win_open);
   modport gate (input ch_active, input scheme_sh, input pixel_clamp_en, input line_clamp_en, input win_open);
endinterface

// >>> logic/strobe_gate.sv
// Purpose: Per-channel gating of sample and clamp strobes
// Assumes: Strobes synchronous to sys_clk
// Notes: Registered outputs, one cycle latency
`timescale 1ns/1ps
module strobe_gate
(
   input wire logic sys_clk,
   input wire logic rst_n,
   afe_cfg_if.gate cfg,
   input wire logic [1:0] reference_sample_strobe,
   input wire logic [1:0] data_sample_strobe,
   input wire logic [1:0] group_clamp_strobe,
   output logic [3:0] ch_ref_sample_en,
   output logic [3:0] ch_data_sample_en,
   output logic [3:0] ch_clamp_en
);
   genvar g;
   generate
      for (g = 0; g < afe_clamp_pkg::num_ch; g++)
      begin : gch
         // Channels 1,2 group A; 3,4 group B
         localparam int grp = g / 2;
         always_ff @(posedge sys_clk)
         begin
            if (!rst_n)
            begin
               ch_ref_sample_en[g] <= 1'b0;
               ch_data_sample_en[g] <= 1'b0;
               ch_clamp_en[g] <= 1'b0;
            end
            else
            begin
               // Reference sample only in double sampling
               ch_ref_sample_en[g] <= cfg.ch_active[g] && !cfg.scheme_sh[g]
                  && reference_sample_strobe[grp];
               ch_data_sample_en[g] <= cfg.ch_active[g] && data_sample_strobe[grp];
               ch_clamp_en[g] <= cfg.ch_active[g] && ((cfg.pixel_clamp_en[g] && group_clamp_strobe[grp])
                  || (cfg.line_clamp_en[g] && cfg.win_open && reference_sample_strobe[grp]));
            end
         end
      end
   endgenerate
endmodule

// >>> logic/afe_channel_clamp_control.sv
// Purpose: Channel mode decode, line clamp window and clamp strobe control
// Assumes: AXI4-Lite slave, sys_clk 20 MHz, synchronous active-low reset
// Notes: Analog selects leave as registered levels
// Function
// - Channel count 0 all active, 1 drops input 4, 2 drops inputs 2 and 4.
// - Per-channel scheme bit, 0 double sampling, 1 single sample-hold.
// - Independent polarity select per channel, routed only to that channel.
// - Double sampling uses reference strobe then data strobe, difference taken.
// - Sample-hold uses data strobe only, difference to clamp reference.
// - Two-bit clamp mode per channel; codes 2 and 3 only in sample-hold.
// - Pixel clamp passes group clamp strobe every pixel period.
// - Line clamp uses reference strobe only inside the window.
// - Line clamp refused when channel uses sample-hold.
// - Channels 1,2 use group A strobes; 3,4 group B.
// - Clamp level select: 0 fixed 2.2 V, 1 internal DAC, 2 external pin.
// - DAC code 2 0.5 V, 3 1.1 V, 0 1.5 V default, 1 2.0 V.
// - Window start and end in sys_clk clocks from line strobe falling edge.
// - Line cycle strobe is one clock wide per line.
// - Window stays high after reset until configured.
`timescale 1ns/1ps
module afe_channel_clamp_control
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic line_cycle_strobe,
   input wire logic [1:0] reference_sample_strobe,
   input wire logic [1:0] data_sample_strobe,
   input wire logic [1:0] group_clamp_strobe,
   output logic [3:0] ch_active,
   output logic [3:0] sampling_scheme_select,
   output logic [3:0] input_polarity_select,
   output logic [7:0] clamp_mode_select,
   output logic [7:0] clamp_level_select,
   output logic [1:0] internal_ref_dac_code,
   output logic [3:0] internal_black_ref_enable,
   output logic line_clamp_window,
   output logic [3:0] ch_ref_sample_en,
   output logic [3:0] ch_data_sample_en,
   output logic [3:0] ch_clamp_en
);
   logic [1:0] count_ff;
   logic [1:0] dac_ff;
   logic [31:0] mode_ff;
   logic [19:0] win_start_ff;
   logic [19:0] win_end_ff;
   logic win_cfg_ff;
   logic [19:0] pix_cnt_ff;
   logic ls_d_ff;
   logic win_ff;
   logic [3:0] err_ff;
   logic [7:0] aw_addr_ff;
   logic aw_have_ff;
   logic [31:0] w_data_ff;
   logic [3:0] w_strb_ff;
   logic w_have_ff;
   logic bvalid_ff;
   logic [1:0] bresp_ff;
   logic rvalid_ff;
   logic [31:0] rdata_ff;
   logic [1:0] rresp_ff;
   logic [3:0] nxt_active;
   logic [3:0] nxt_pix_en;
   logic [3:0] nxt_line_en;
   logic [3:0] nxt_err;
   logic do_write;
   logic ls_fall;
   logic [31:0] nxt_rdata;
   logic rd_ok;

   afe_cfg_if cfg_bus ();

   function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
                                               input logic [3:0] strb);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++)
      begin
         if (strb[b])
            r[b*8 +: 8] = new_v[b*8 +: 8];
      end
      return r;
   endfunction

   function automatic logic [1:0] ch_clamp(input logic [31:0] m, input int ch);
      return m[ch*afe_clamp_pkg::ch_field_w + afe_clamp_pkg::fld_clamp_lo +: 2];
   endfunction

   // Channel count decode
   always_comb
   begin
      unique case (count_ff)
         afe_clamp_pkg::count_three: nxt_active = 4'h7;
         afe_clamp_pkg::count_two: nxt_active = 4'h5;
         default: nxt_active = 4'hF;
      endcase
   end

   // Mode decode; illegal mode/scheme combinations fall back to no clamp and flag an error, level code 3 only flags
   always_comb
   begin
      nxt_pix_en = 4'h0;
      nxt_line_en = 4'h0;
      nxt_err = 4'h0;
      for (int c = 0; c < afe_clamp_pkg::num_ch; c++)
      begin
         unique case (afe_clamp_pkg::clamp_mode_t'(ch_clamp(mode_ff, c)))
            afe_clamp_pkg::clamp_pixel: nxt_pix_en[c] = 1'b1;
            afe_clamp_pkg::clamp_line:
            begin
               // Droop too large without a reference sample
               nxt_line_en[c] = !mode_ff[c*afe_clamp_pkg::ch_field_w + afe_clamp_pkg::fld_scheme];
               nxt_err[c] = mode_ff[c*afe_clamp_pkg::ch_field_w + afe_clamp_pkg::fld_scheme];
            end
            afe_clamp_pkg::clamp_open_int, afe_clamp_pkg::clamp_open_ext:
               nxt_err[c] = !mode_ff[c*afe_clamp_pkg::ch_field_w + afe_clamp_pkg::fld_scheme];
         endcase
         if (mode_ff[c*afe_clamp_pkg::ch_field_w + afe_clamp_pkg::fld_level_lo +: 2] == 2'h3)
            nxt_err[c] = 1'b1;
      end
   end

   // Registered decode keeps strobes from glitching mid pixel
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         cfg_bus.ch_active <= 4'hF;
         cfg_bus.scheme_sh <= 4'h0;
         cfg_bus.pixel_clamp_en <= 4'hF;
         cfg_bus.line_clamp_en <= 4'h0;
         err_ff <= 4'h0;
      end
      else
      begin
         cfg_bus.ch_active <= nxt_active;
         cfg_bus.pixel_clamp_en <= nxt_pix_en;
         cfg_bus.line_clamp_en <= nxt_line_en;
         err_ff <= nxt_err;
         for (int c = 0; c < afe_clamp_pkg::num_ch; c++)
         begin
            cfg_bus.scheme_sh[c] <= mode_ff[c*afe_clamp_pkg::ch_field_w + afe_clamp_pkg::fld_scheme];
         end
      end
   end

   // Analog select outputs
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         sampling_scheme_select <= 4'h0;
         input_polarity_select <= 4'h0;
         clamp_mode_select <= 8'h00;
         clamp_level_select <= 8'h00;
         internal_ref_dac_code <= afe_clamp_pkg::dac_reset;
         internal_black_ref_enable <= 4'h0;
         ch_active <= 4'hF;
      end
      else
      begin
         internal_ref_dac_code <= dac_ff;
         ch_active <= nxt_active;
         for (int c = 0; c < afe_clamp_pkg::num_ch; c++)
         begin
            sampling_scheme_select[c] <= mode_ff[c*afe_clamp_pkg::ch_field_w + afe_clamp_pkg::fld_scheme];
            input_polarity_select[c] <= mode_ff[c*afe_clamp_pkg::ch_field_w + afe_clamp_pkg::fld_polarity];
            clamp_mode_select[c*2 +: 2] <= ch_clamp(mode_ff, c);
            clamp_level_select[c*2 +: 2] <=
               mode_ff[c*afe_clamp_pkg::ch_field_w + afe_clamp_pkg::fld_level_lo +: 2];
            internal_black_ref_enable[c] <= (ch_clamp(mode_ff, c) == 2'(afe_clamp_pkg::clamp_open_int))
               && mode_ff[c*afe_clamp_pkg::ch_field_w + afe_clamp_pkg::fld_scheme];
         end
      end
   end

   // Clock counter (one count per sys_clk) from the line strobe falling edge
   assign ls_fall = ls_d_ff && !line_cycle_strobe;

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         ls_d_ff <= 1'b0;
         pix_cnt_ff <= afe_clamp_pkg::win_reset;
      end
      else
      begin
         ls_d_ff <= line_cycle_strobe;
         if (ls_fall)
            pix_cnt_ff <= afe_clamp_pkg::win_reset;
         else if (pix_cnt_ff != 20'hFFFFF)
            pix_cnt_ff <= pix_cnt_ff + 20'h00001;
      end
   end

   // Window: open at start count, closed at end count; high until configured
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n || !win_cfg_ff)
         win_ff <= 1'b1;
      else
         win_ff <= (pix_cnt_ff >= win_start_ff) && (pix_cnt_ff < win_end_ff);
   end

   assign line_clamp_window = win_ff;
   assign cfg_bus.win_open = win_ff;

   strobe_gate u_gate
   (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .cfg(cfg_bus.gate),
      .reference_sample_strobe(reference_sample_strobe),
      .data_sample_strobe(data_sample_strobe),
      .group_clamp_strobe(group_clamp_strobe),
      .ch_ref_sample_en(ch_ref_sample_en),
      .ch_data_sample_en(ch_data_sample_en),
      .ch_clamp_en(ch_clamp_en)
   );

   // AXI write channel capture, address and data in either order
   assign s_axi_awready = !aw_have_ff && !bvalid_ff;
   assign s_axi_wready = !w_have_ff && !bvalid_ff;
   assign do_write = aw_have_ff && w_have_ff && !bvalid_ff;

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         aw_have_ff <= 1'b0;
         w_have_ff <= 1'b0;
         aw_addr_ff <= 8'h00;
         w_data_ff <= 32'h00000000;
         w_strb_ff <= 4'h0;
         bvalid_ff <= 1'b0;
         bresp_ff <= afe_clamp_pkg::resp_okay;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_have_ff <= 1'b1;
            aw_addr_ff <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_have_ff <= 1'b1;
            w_data_ff <= s_axi_wdata;
            w_strb_ff <= s_axi_wstrb;
         end
         if (do_write)
         begin
            aw_have_ff <= 1'b0;
            w_have_ff <= 1'b0;
            bvalid_ff <= 1'b1;
            unique case ({aw_addr_ff[7:2], 2'h0})
               afe_clamp_pkg::off_chan_cfg, afe_clamp_pkg::off_ch_mode, afe_clamp_pkg::off_win_start,
               afe_clamp_pkg::off_win_end, afe_clamp_pkg::off_status: bresp_ff <= afe_clamp_pkg::resp_okay;
               default: bresp_ff <= afe_clamp_pkg::resp_slverr;
            endcase
         end
         else if (bvalid_ff && s_axi_bready)
         begin
            bvalid_ff <= 1'b0;
         end
      end
   end

   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;

   // Register file
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         count_ff <= afe_clamp_pkg::count_four;
         dac_ff <= afe_clamp_pkg::dac_reset;
         mode_ff <= 32'h00000000;
         win_start_ff <= afe_clamp_pkg::win_reset;
         win_end_ff <= afe_clamp_pkg::win_reset;
         win_cfg_ff <= 1'b0;
      end
      else if (do_write)
      begin
         unique case ({aw_addr_ff[7:2], 2'h0})
            afe_clamp_pkg::off_chan_cfg:
               if (w_strb_ff[0])
               begin
                  dac_ff <= w_data_ff[afe_clamp_pkg::fld_dac_lo +: 2];
                  count_ff <= w_data_ff[afe_clamp_pkg::fld_count_lo +: 2];
               end
            afe_clamp_pkg::off_ch_mode: mode_ff <= merge_bytes(mode_ff, w_data_ff, w_strb_ff);
            afe_clamp_pkg::off_win_start:
            begin
               win_start_ff <= 20'(merge_bytes({12'h000, win_start_ff}, w_data_ff, w_strb_ff));
               win_cfg_ff <= 1'b1;
            end
            afe_clamp_pkg::off_win_end:
            begin
               win_end_ff <= 20'(merge_bytes({12'h000, win_end_ff}, w_data_ff, w_strb_ff));
               win_cfg_ff <= 1'b1;
            end
            default: ;
         endcase
      end
   end

   // Read path
   always_comb
   begin
      nxt_rdata = 32'h00000000;
      rd_ok = 1'b1;
      unique case ({s_axi_araddr[7:2], 2'h0})
         afe_clamp_pkg::off_chan_cfg: nxt_rdata = {28'h0000000, count_ff, dac_ff};
         afe_clamp_pkg::off_ch_mode: nxt_rdata = mode_ff;
         afe_clamp_pkg::off_win_start: nxt_rdata = {12'h000, win_start_ff};
         afe_clamp_pkg::off_win_end: nxt_rdata = {12'h000, win_end_ff};
         afe_clamp_pkg::off_status: nxt_rdata = {22'h000000, win_cfg_ff, win_ff, err_ff, cfg_bus.ch_active};
         default: rd_ok = 1'b0;
      endcase
   end

   assign s_axi_arready = !rvalid_ff;

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h00000000;
         rresp_ff <= afe_clamp_pkg::resp_okay;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         rvalid_ff <= 1'b1;
         rdata_ff <= nxt_rdata;
         rresp_ff <= rd_ok ? afe_clamp_pkg::resp_okay : afe_clamp_pkg::resp_slverr;
      end
      else if (rvalid_ff && s_axi_rready)
         rvalid_ff <= 1'b0;
   end

   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata = rdata_ff;
   assign s_axi_rresp = rresp_ff;
endmodule

// >>> bench/sensor_model.sv
// Purpose: Line sensor strobe source for the clamp controller bench
// Assumes: Four clocks per pixel, sixteen pixels per line
// Notes: Group B runs two phases behind group A
`timescale 1ns/1ps
module sensor_model
(
   input wire logic sys_clk,
   input wire logic rst_n,
   output logic line_cycle_strobe,
   output logic [1:0] reference_sample_strobe,
   output logic [1:0] data_sample_strobe,
   output logic [1:0] group_clamp_strobe
);
   logic [5:0] phase_ff = 6'h00;
   initial
   begin
      line_cycle_strobe = 1'b0;
      reference_sample_strobe = 2'h0;
      data_sample_strobe = 2'h0;
      group_clamp_strobe = 2'h0;
   end
   always @(posedge sys_clk)
   begin
      phase_ff <= rst_n ? phase_ff + 6'h01 : 6'h00;
      line_cycle_strobe <= rst_n && phase_ff == 6'h3F;
      group_clamp_strobe <= {phase_ff[1:0] == 2'h2, phase_ff[1:0] == 2'h0};
      // Reference and data phases never meet within a group
      reference_sample_strobe <= {phase_ff[1:0] == 2'h3, phase_ff[1:0] == 2'h1};
      data_sample_strobe <= {phase_ff[1:0] == 2'h1, phase_ff[1:0] == 2'h3};
   end
endmodule

// >>> bench/afe_clamp_checker.sv
// Purpose: Port-level checks of the clamp controller
// Assumes: Single clock, synchronous active-low reset
// Notes: Gating lags its causes by one clock
`timescale 1ns/1ps
module afe_clamp_checker
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [1:0] reference_sample_strobe,
   input wire logic [1:0] data_sample_strobe,
   input wire logic [1:0] group_clamp_strobe,
   input wire logic [3:0] ch_active,
   input wire logic [3:0] sampling_scheme_select,
   input wire logic [7:0] clamp_mode_select,
   input wire logic [3:0] internal_black_ref_enable,
   input wire logic line_clamp_window,
   input wire logic [3:0] ch_ref_sample_en,
   input wire logic [3:0] ch_data_sample_en,
   input wire logic [3:0] ch_clamp_en
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   AST_DECODE: assert property (ch_active inside {4'hF, 4'h7, 4'h5})
      else $error("channel decode outside table");
   // Antecedents need rst_n sampled high: the release edge still holds enables low
   AST_STANDBY: assert property (rst_n |=>
      ((~$past(ch_active)) & (ch_ref_sample_en | ch_data_sample_en | ch_clamp_en)) == 4'h0)
      else $error("standby channel strobed");
   AST_DATA_GROUP: assert property (rst_n |=>
      ch_data_sample_en == ($past(ch_active)
      & {{2{$past(data_sample_strobe[1])}}, {2{$past(data_sample_strobe[0])}}}))
      else $error("data sample enable wrong");
   AST_REF_GROUP: assert property (rst_n |=>
      ch_ref_sample_en == ($past(ch_active & ~sampling_scheme_select)
      & {{2{$past(reference_sample_strobe[1])}}, {2{$past(reference_sample_strobe[0])}}}))
      else $error("reference sample enable wrong");
   AST_PIXEL_CLAMP: assert property (rst_n && ch_active[0] && clamp_mode_select[1:0] == 2'h0 |=>
      ch_clamp_en[0] == $past(group_clamp_strobe[0]))
      else $error("pixel clamp not following clamp strobe");
   AST_LINE_CLAMP: assert property (rst_n && ch_active[2] && clamp_mode_select[5:4] == 2'h1
      && !sampling_scheme_select[2] |=> ch_clamp_en[2] == $past(line_clamp_window && reference_sample_strobe[1]))
      else $error("line clamp outside window");
   AST_LINE_SH_OFF: assert property (rst_n && clamp_mode_select[1:0] == 2'h1 && sampling_scheme_select[0]
      |=> !ch_clamp_en[0])
      else $error("line clamp in sample-hold");
   AST_BLACK_REF: assert property (internal_black_ref_enable[1]
      == (clamp_mode_select[3:2] == 2'h2 && sampling_scheme_select[1]))
      else $error("black reference enable wrong");
   AST_WIN_RESET: assert property ($rose(rst_n) |-> line_clamp_window [*8])
      else $error("window low after reset");
   cover property (ch_clamp_en[2]);
   cover property (ch_active == 4'h5);
   cover property ($fell(line_clamp_window));
endmodule
bind afe_channel_clamp_control afe_clamp_checker i_afe_clamp_checker (.sys_clk, .rst_n, .reference_sample_strobe,
   .data_sample_strobe, .group_clamp_strobe, .ch_active, .sampling_scheme_select, .clamp_mode_select,
   .internal_black_ref_enable, .line_clamp_window, .ch_ref_sample_en, .ch_data_sample_en, .ch_clamp_en);

// >>> bench/tb_afe_channel_clamp_control.sv
// Purpose: Self-checking bench for the channel clamp controller
// Assumes: Bench is the AXI4-Lite master, sensor_model makes strobes
// Notes: A line is 64 clocks, so counts run over 64 clocks
`timescale 1ns/1ps
module tb_afe_channel_clamp_control;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, line_cycle_strobe, line_clamp_window;
   logic [1:0] s_axi_bresp, s_axi_rresp, reference_sample_strobe, data_sample_strobe, group_clamp_strobe;
   logic [1:0] internal_ref_dac_code;
   logic [3:0] ch_active, sampling_scheme_select, input_polarity_select, internal_black_ref_enable;
   logic [3:0] ch_ref_sample_en, ch_data_sample_en, ch_clamp_en;
   logic [7:0] clamp_mode_select, clamp_level_select;
   int miscompares = 0;
   int n_compared = 0;
   int cycles = 0;
   always #25 sys_clk = ~sys_clk;
   sensor_model i_sensor_model (.sys_clk, .rst_n, .line_cycle_strobe, .reference_sample_strobe, .data_sample_strobe,
      .group_clamp_strobe);
   afe_channel_clamp_control i_afe_channel_clamp_control (.sys_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .line_cycle_strobe, .reference_sample_strobe, .data_sample_strobe, .group_clamp_strobe,
      .ch_active, .sampling_scheme_select, .input_polarity_select, .clamp_mode_select, .clamp_level_select,
      .internal_ref_dac_code, .internal_black_ref_enable, .line_clamp_window, .ch_ref_sample_en, .ch_data_sample_en,
      .ch_clamp_en);
   task automatic report_and_stop();
      $display("compared %0d, mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Hang guard, the whole run needs under 2000 clocks
   always @(posedge sys_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         miscompares++;
         report_and_stop();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_compared++;
      if (got !== exp)
      begin
         miscompares++;
         $display("mismatch at %0t: %s got %0h expected %0h", $time, what, got, exp);
      end
   endtask
   task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge sys_clk);
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end
      while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      // Selects settle on this edge; look at them once they have
      @(negedge sys_clk);
   endtask
   task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge sys_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge sys_clk);
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
      end
      while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   // Two clocks first, so gating has caught up with the last write
   task automatic count_hi(input int sel, input int ch, output int n);
      n = 0;
      repeat (2) @(posedge sys_clk);
      repeat (64)
      begin
         @(posedge sys_clk);
         case (sel)
            0: n += ch_ref_sample_en[ch];
            1: n += ch_data_sample_en[ch];
            2: n += ch_clamp_en[ch];
            default: n += line_clamp_window;
         endcase
      end
   endtask
   task automatic test_counts_and_dac();
      logic [1:0] r;
      logic [3:0] act [3] = '{4'hF, 4'h7, 4'h5};
      int n;
      for (int c = 0; c < 3; c++)
      begin
         axw(afe_clamp_pkg::off_chan_cfg, 32'(c * 4), r);
         chk(ch_active, act[c], "active decode");
         count_hi(1, 3, n);
         chk(n, c == 0 ? 16 : 0, "input 4 data enable");
      end
      for (int d = 0; d < 4; d++)
      begin
         axw(afe_clamp_pkg::off_chan_cfg, 32'(d), r);
         chk(internal_ref_dac_code, 32'(d), "dac code");
      end
      $display("test counts_and_dac done");
   endtask
   task automatic test_modes_and_window();
      logic [31:0] d;
      logic [1:0] r;
      int n;
      count_hi(3, 0, n);
      chk(n, 64, "window before setup");
      axw(afe_clamp_pkg::off_ch_mode, 32'h0F241902, r);
      chk(sampling_scheme_select, 4'hA, "scheme");
      chk(input_polarity_select, 4'h9, "polarity");
      chk(clamp_mode_select, 8'hD8, "clamp modes");
      chk(clamp_level_select, 8'h24, "clamp levels");
      chk(internal_black_ref_enable, 4'h2, "black ref");
      count_hi(0, 1, n);
      chk(n, 0, "sample-hold ref enable");
      count_hi(1, 1, n);
      chk(n, 16, "sample-hold data enable");
      count_hi(0, 0, n);
      chk(n, 16, "double sampling ref enable");
      count_hi(2, 0, n);
      chk(n, 16, "pixel clamp");
      count_hi(2, 3, n);
      chk(n, 0, "unclamped channel");
      count_hi(2, 2, n);
      chk(n, 16, "line clamp, window open");
      axw(afe_clamp_pkg::off_win_start, 32'h2, r);
      axw(afe_clamp_pkg::off_win_end, 32'hA, r);
      count_hi(3, 0, n);
      chk(n, 8, "window width");
      count_hi(2, 2, n);
      chk(n, 2, "line clamp in window");
      axr(afe_clamp_pkg::off_status, d, r);
      chk(d[9], 1'b1, "window configured");
      axw(afe_clamp_pkg::off_ch_mode, 32'h0F241905, r);
      count_hi(2, 0, n);
      chk(n, 0, "line clamp with sample-hold");
      axr(afe_clamp_pkg::off_status, d, r);
      chk(d[4], 1'b1, "config error flag");
      $display("test modes_and_window done");
   endtask
   task automatic test_bus_and_reset();
      logic [31:0] d;
      logic [1:0] r;
      axr(8'h14, d, r);
      chk(r, afe_clamp_pkg::resp_slverr, "unmapped read response");
      chk(d, 32'h0, "unmapped read data");
      axw(8'h14, 32'hFFFFFFFF, r);
      chk(r, afe_clamp_pkg::resp_slverr, "unmapped write response");
      @(posedge sys_clk);
      rst_n <= 1'b0;
      repeat (8) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      chk(line_clamp_window, 1'b1, "window after reset");
      chk(ch_active, 4'hF, "active after reset");
      chk(clamp_mode_select, 8'h00, "pixel clamp default");
      axr(afe_clamp_pkg::off_status, d, r);
      chk(d[9:0], 10'h10F, "status after reset");
      axr(afe_clamp_pkg::off_chan_cfg, d, r);
      chk(d, 32'h0, "dac default");
      $display("test bus_and_reset done");
   endtask
   initial
   begin
      repeat (8) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      test_counts_and_dac();
      test_modes_and_window();
      test_bus_and_reset();
      report_and_stop();
   end
endmodule
